/* File: common/msgbuf_pkg.sv */
// shared constants and types for the message buffer block
`default_nettype none
package msgbuf_pkg;
  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 8;
  localparam int USER_W    = 8;
  localparam int BUF_BYTES = 32'h0002_0000;
  localparam int BUF_WORDS = BUF_BYTES / 4;
  localparam int PTR_W     = $clog2(BUF_WORDS);
  localparam int FIFO_DEP  = 16;
  localparam int FIFO_W    = DATA_W + PTR_W;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_LOCK   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CMD    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DLEN   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IN     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_OUT    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EXEC   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
  // eight info words at 0x20..0x3C
  localparam logic [2:0] INFO_SEL = 3'h1;
  localparam int INFO_N   = 8;
  // field positions and reset values
  localparam int EXEC_BIT = 0;
  localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
  // status outcome codes
  typedef enum logic [1:0] {
    ST_BUSY       = 2'h0,
    ST_DATA_READY = 2'h1,
    ST_COMPLETE   = 2'h2,
    ST_FAILURE    = 2'h3
  } status_e;
  // access engine states
  typedef enum logic [3:0] {
    ENG_IDLE   = 4'h1,
    ENG_EXEC   = 4'h2,
    ENG_RDWAIT = 4'h4,
    ENG_RESP   = 4'h8
  } engine_e;
endpackage
`default_nettype wire

/* File: common/msgbuf_ram_if.sv */
// single-port buffer memory connection
`timescale 1ns/1ns
`default_nettype none
interface msgbuf_ram_if;
  import msgbuf_pkg::*;
  logic              en;
  logic              we;
  logic [PTR_W-1:0]  addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: hw/msgbuf_fifo.sv */
// parameterised valid/ready word fifo
`timescale 1ns/1ns
`default_nettype none
module msgbuf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // filling side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // draining side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW-1:0]    wp_reg;
  logic [AW-1:0]    rp_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  // honest full and empty from the fill count
  assign inReady  = (cnt_reg != DEPTH[AW:0]);
  assign outValid = (cnt_reg != '0);
  assign outData  = store[rp_reg];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      store[wp_reg] <= inData;
    end
  end

  // pointers and count
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

/* File: hw/msgbuf_ram.sv */
// buffer memory, synchronous read
`timescale 1ns/1ns
`default_nettype none
module msgbuf_ram (
  // clock
  input wire logic clk,
  // memory port
  msgbuf_ram_if.mem port
);
  import msgbuf_pkg::*;
  logic [DATA_W-1:0] mem [0:BUF_WORDS-1];

  // one access per cycle, read data next cycle
  always_ff @(posedge clk) begin
    if (port.en) begin
      if (port.we) begin
        mem[port.addr] <= port.wdata;
      end else begin
        port.rdata <= mem[port.addr];
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/soc_core_mailbox_with_lock.sv */
// lock-guarded message buffer between system-on-chip and embedded core
//
// How it works
// [RULE1] 128KB word buffer holds command payloads
// [RULE2] soc reaches everything through apb only
// [RULE3] soc execute raises interrupt to core
// [RULE4] core execute drives wire and status
// [RULE5] lock read of zero grants, sets lock
// [RULE6] requester reading one backs off
// [RULE7] sender: command, length, data, then execute
// [RULE8] status reports one of four outcomes
// [RULE9] only lock holder writes are accepted; core status and info writes and receiver execute-clear bypass the lock
// [RULE10] lock held until release or forced end
// [RULE11] receiver reads command, length, then data
// [RULE12] clearing execute releases the lock
// [RULE13] filled buffer shown by wire and status
// [RULE14] pauser checked against lock owner
// [RULE15] reserved pauser may claim lock next
// [RULE16] soc access permissions per register
// [RULE17] buffer writes dropped until enabled
// [RULE18] fixed binary code per outcome
// [RULE19] word pointers advance, reset on grant
`timescale 1ns/1ns
`default_nettype none
module soc_core_mailbox_with_lock (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // apb completer, system-on-chip side
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [msgbuf_pkg::ADDR_W-1:0] paddr,
  input  wire logic [msgbuf_pkg::DATA_W-1:0] pwdata,
  input  wire logic [msgbuf_pkg::USER_W-1:0] pauser,
  output logic                               pready,
  output logic [msgbuf_pkg::DATA_W-1:0]      prdata,
  output logic                               pslverr,
  // embedded core register port
  input  wire logic                          coreReq,
  input  wire logic                          coreWrite,
  input  wire logic [msgbuf_pkg::ADDR_W-1:0] coreAddr,
  input  wire logic [msgbuf_pkg::DATA_W-1:0] coreWdata,
  output logic                               coreAck,
  output logic [msgbuf_pkg::DATA_W-1:0]      coreRdata,
  output logic                               coreErr,
  // boot enable and lock policy
  input  wire logic                          bufferEnable,
  input  wire logic                          lockForceRelease,
  input  wire logic                          lockReserveValid,
  input  wire logic [msgbuf_pkg::USER_W-1:0] lockReserveUser,
  // notifications
  output logic                               coreIrq,
  output logic                               socNotify
);
  import msgbuf_pkg::*;

  // latched request
  engine_e           state_reg;
  logic              reqSoc_reg;
  logic              reqWr_reg;
  logic [ADDR_W-1:0] reqAddr_reg;
  logic [DATA_W-1:0] reqData_reg;
  logic [USER_W-1:0] reqUser_reg;
  // lock and message state
  logic              lockHeld_reg;
  logic              ownerSoc_reg;
  logic [USER_W-1:0] ownerUser_reg;
  logic [DATA_W-1:0] cmd_reg;
  logic [DATA_W-1:0] dlen_reg;
  logic              exec_reg;
  status_e           status_reg;
  logic [DATA_W-1:0] info_reg [0:INFO_N-1];
  logic [PTR_W-1:0]  wrPtr_reg;
  logic [PTR_W-1:0]  rdPtr_reg;
  // decode
  logic              selLock;
  logic              selCmd;
  logic              selDlen;
  logic              selIn;
  logic              selOut;
  logic              selExec;
  logic              selStatus;
  logic              selInfo;
  logic [2:0]        infoIdx;
  logic              errResp;
  logic              ownerHit;
  logic              recvHit;
  logic              writeOk;
  logic              readOk;
  logic              reserveBlock;
  logic              stall;
  logic              act;
  logic              ramRead;
  logic              respFire;
  logic [DATA_W-1:0] regRdata;
  logic [DATA_W-1:0] respData;
  // events
  logic              grant;
  logic              release_ev;
  logic              execSet;
  logic              pushIn;
  // fifo wiring
  logic              fifoInReady;
  logic              fifoOutValid;
  logic              fifoOutReady;
  logic [FIFO_W-1:0] fifoOutData;

  msgbuf_ram_if ram ();

  // helper: zero a word unless access is allowed
  function automatic logic [DATA_W-1:0] gate(input logic ok, input logic [DATA_W-1:0] v);
    gate = ok ? v : WORD_RST;
  endfunction

  // address decode of the latched request
  always_comb begin
    selLock   = (reqAddr_reg == OFS_LOCK);
    selCmd    = (reqAddr_reg == OFS_CMD);
    selDlen   = (reqAddr_reg == OFS_DLEN);
    selIn     = (reqAddr_reg == OFS_IN);
    selOut    = (reqAddr_reg == OFS_OUT);
    selExec   = (reqAddr_reg == OFS_EXEC);
    selStatus = (reqAddr_reg == OFS_STATUS);
    selInfo   = (reqAddr_reg[7:5] == INFO_SEL) && (reqAddr_reg[1:0] == 2'h0);
    infoIdx   = reqAddr_reg[4:2];
  end

  // [RULE16] soc permission table
  always_comb begin
    errResp = !(selLock || selCmd || selDlen || selIn || selOut
                || selExec || selStatus || selInfo);
    if (reqWr_reg && (selLock || selOut)) begin
      errResp = 1'b1;
    end
    if (reqWr_reg && reqSoc_reg && (selStatus || selInfo)) begin
      errResp = 1'b1;
    end
    if (!reqWr_reg && selIn) begin
      errResp = 1'b1;
    end
  end

  // [RULE14] owner identity includes pauser
  assign ownerHit = lockHeld_reg && (ownerSoc_reg == reqSoc_reg)
                    && (!reqSoc_reg || (ownerUser_reg == reqUser_reg));
  assign recvHit  = lockHeld_reg && exec_reg && (ownerSoc_reg != reqSoc_reg);
  // [RULE9] writes only from lock holder
  // [RULE17] dropped while buffer disabled
  assign writeOk  = ownerHit && bufferEnable;
  assign readOk   = ownerHit || recvHit;
  // [RULE15] reserved requester gets the next lock
  assign reserveBlock = lockReserveValid
                        && (!reqSoc_reg || (reqUser_reg != lockReserveUser));

  // stalls: full fifo, or execute before data has landed
  assign stall = !errResp && reqWr_reg && writeOk
                 && ((selIn && !fifoInReady)
                     || (selExec && reqData_reg[EXEC_BIT] && fifoOutValid));
  assign act      = (state_reg == ENG_EXEC) && !stall;
  assign ramRead  = act && !errResp && !reqWr_reg && selOut && readOk;
  assign respFire = (act && !ramRead) || (state_reg == ENG_RDWAIT);

  // [RULE5] grant on lock read returning zero
  assign grant = act && !errResp && !reqWr_reg && selLock
                 && !lockHeld_reg && !reserveBlock;
  // [RULE12] clearing execute ends ownership
  // [RULE10] forced end of the lock, whether execute is set or not
  assign release_ev = lockForceRelease
                      || (act && !errResp && reqWr_reg && selExec
                          && !reqData_reg[EXEC_BIT] && (ownerHit || recvHit));
  assign execSet = act && !errResp && reqWr_reg && selExec
                   && reqData_reg[EXEC_BIT] && writeOk && !exec_reg;
  assign pushIn  = act && !errResp && reqWr_reg && selIn && writeOk;

  // read data mux for register reads
  always_comb begin
    regRdata = WORD_RST;
    case (1'b1)
      selLock:   regRdata = {31'h0, lockHeld_reg || reserveBlock};
      selCmd:    regRdata = gate(readOk, cmd_reg);
      selDlen:   regRdata = gate(readOk, dlen_reg);
      selExec:   regRdata = {31'h0, exec_reg};
      selStatus: regRdata = gate(readOk, {30'h0, status_reg});
      selInfo:   regRdata = info_reg[infoIdx];
      default:   regRdata = WORD_RST;
    endcase
  end
  assign respData = (state_reg == ENG_RDWAIT) ? ram.rdata : regRdata;

  // access engine, one request at a time, soc first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg   <= ENG_IDLE;
      reqSoc_reg  <= 1'b0;
      reqWr_reg   <= 1'b0;
      reqAddr_reg <= 8'h00;
      reqData_reg <= WORD_RST;
      reqUser_reg <= 8'h00;
    end else begin
      case (state_reg)
        // [RULE2] soc requests arrive as apb accesses
        ENG_IDLE: begin
          if (psel && penable) begin
            reqSoc_reg  <= 1'b1;
            reqWr_reg   <= pwrite;
            reqAddr_reg <= paddr;
            reqData_reg <= pwdata;
            reqUser_reg <= pauser;
            state_reg   <= ENG_EXEC;
          end else if (coreReq) begin
            reqSoc_reg  <= 1'b0;
            reqWr_reg   <= coreWrite;
            reqAddr_reg <= coreAddr;
            reqData_reg <= coreWdata;
            reqUser_reg <= 8'h00;
            state_reg   <= ENG_EXEC;
          end
        end
        ENG_EXEC: begin
          if (ramRead) begin
            state_reg <= ENG_RDWAIT;
          end else if (!stall) begin
            state_reg <= ENG_RESP;
          end
        end
        ENG_RDWAIT: state_reg <= ENG_RESP;
        ENG_RESP:   state_reg <= ENG_IDLE;
        default:    state_reg <= ENG_IDLE;
      endcase
    end
  end

  // answers, one-cycle ready or ack
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready    <= 1'b0;
      prdata    <= WORD_RST;
      pslverr   <= 1'b0;
      coreAck   <= 1'b0;
      coreRdata <= WORD_RST;
      coreErr   <= 1'b0;
    end else begin
      pready  <= 1'b0;
      coreAck <= 1'b0;
      if (respFire && reqSoc_reg) begin
        pready  <= 1'b1;
        prdata  <= respData;
        pslverr <= errResp;
      end else if (respFire) begin
        coreAck   <= 1'b1;
        coreRdata <= respData;
        coreErr   <= errResp;
      end
    end
  end

  // lock ownership
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lockHeld_reg  <= 1'b0;
      ownerSoc_reg  <= 1'b0;
      ownerUser_reg <= 8'h00;
    end else if (grant) begin
      lockHeld_reg  <= 1'b1;
      ownerSoc_reg  <= reqSoc_reg;
      ownerUser_reg <= reqUser_reg;
    end else if (release_ev) begin
      lockHeld_reg <= 1'b0;
    end
  end

  // [RULE7] command and length from the owner
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_reg  <= WORD_RST;
      dlen_reg <= WORD_RST;
    end else if (act && !errResp && reqWr_reg && writeOk) begin
      if (selCmd) begin
        cmd_reg <= reqData_reg;
      end
      if (selDlen) begin
        dlen_reg <= reqData_reg;
      end
    end
  end

  // execute, status and notifications
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      exec_reg   <= 1'b0;
      status_reg <= ST_BUSY;
      coreIrq    <= 1'b0;
      socNotify  <= 1'b0;
    end else begin
      coreIrq <= 1'b0;
      if (execSet) begin
        exec_reg <= 1'b1;
        if (ownerSoc_reg) begin
          // [RULE3] command waiting for the core
          coreIrq    <= 1'b1;
          status_reg <= ST_BUSY;
        end else begin
          // [RULE4] wire plus status toward the soc
          // [RULE13] data ready shown both ways
          socNotify  <= 1'b1;
          status_reg <= ST_DATA_READY;
        end
      end else if (release_ev) begin
        exec_reg  <= 1'b0;
        socNotify <= 1'b0;
      end else if (act && !errResp && reqWr_reg && selStatus) begin
        // [RULE8] core posts the outcome
        // [RULE18] code taken from the low two bits
        status_reg <= status_e'(reqData_reg[1:0]);
      end
    end
  end

  // core-written error, boot and flow words
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < INFO_N; i++) begin
        info_reg[i] <= WORD_RST;
      end
    end else if (act && !errResp && reqWr_reg && selInfo) begin
      info_reg[infoIdx] <= reqData_reg;
    end
  end

  // [RULE19] word pointers, cleared on each grant
  // [RULE11] receiver walks outbound words in order
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else if (grant) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (pushIn) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (ramRead) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end

  // inbound words queue ahead of the memory
  msgbuf_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEP)
  ) inFifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inValid  (pushIn),
    .inReady  (fifoInReady),
    .inData   ({wrPtr_reg, reqData_reg}),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // memory port: outbound reads win, fifo drain waits
  assign fifoOutReady = !ramRead;
  assign ram.en    = ramRead || fifoOutValid;
  assign ram.we    = !ramRead;
  assign ram.addr  = ramRead ? rdPtr_reg : fifoOutData[FIFO_W-1:DATA_W];
  assign ram.wdata = fifoOutData[DATA_W-1:0];

  // [RULE1] the shared payload store
  msgbuf_ram buffer (
    .clk  (clk),
    .port (ram.mem)
  );
endmodule
`default_nettype wire

/* File: sim/msgbuf_props.sv */
// port-level assertions for the message buffer block
`timescale 1ns/1ns
`default_nettype none
module msgbuf_props
  import msgbuf_pkg::*;
(
  // clock and reset
  input wire logic                          clk,
  input wire logic                          sys_rst,
  // apb side
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [msgbuf_pkg::ADDR_W-1:0] paddr,
  input wire logic                          pready,
  // core side
  input wire logic                          coreReq,
  input wire logic                          coreWrite,
  input wire logic [msgbuf_pkg::ADDR_W-1:0] coreAddr,
  input wire logic                          coreAck,
  // policy and notifications
  input wire logic                          lockForceRelease,
  input wire logic                          coreIrq,
  input wire logic                          socNotify
);
  logic socExec;
  logic coreExec;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // writes aimed at execute
  assign socExec  = psel && pwrite && (paddr == OFS_EXEC);
  assign coreExec = coreReq && coreWrite && (coreAddr == OFS_EXEC);
  // start of an access phase
  sequence apbStart;
    psel && penable && !$past(penable);
  endsequence
  sequence coreStart;
    coreReq && !$past(coreReq);
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=>
    !pready && !coreAck && !coreIrq && !socNotify) else $error("outputs busy after reset");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_apb_latency: assert property (apbStart |-> ##[2:40] pready)
    else $error("apb answer missing");
  a_ack_pulse: assert property (coreAck |=> !coreAck)
    else $error("coreAck longer than one cycle");
  a_ack_latency: assert property (coreStart |-> ##[2:40] coreAck)
    else $error("core answer missing");
  a_irq_pulse: assert property (coreIrq |=> !coreIrq)
    else $error("coreIrq longer than one cycle");
  a_irq_cause: assert property (coreIrq |-> socExec || $past(socExec))
    else $error("coreIrq without execute write");
  a_notify_cause: assert property ($rose(socNotify) |-> coreExec || $past(coreExec))
    else $error("socNotify without core execute");
  a_force_clear: assert property (lockForceRelease |-> ##[1:2] !socNotify)
    else $error("socNotify kept after forced release");
endmodule
bind soc_core_mailbox_with_lock msgbuf_props chk (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .coreReq(coreReq),
  .coreWrite(coreWrite), .coreAddr(coreAddr), .coreAck(coreAck),
  .lockForceRelease(lockForceRelease), .coreIrq(coreIrq), .socNotify(socNotify));
`default_nettype wire

/* File: sim/msgbuf_partner.sv */
// apb requester and core firmware model facing the message buffer
`timescale 1ns/1ns
`default_nettype none
module msgbuf_partner
  import msgbuf_pkg::*;
(
  // clock
  input wire logic                          clk,
  // apb requester
  output logic                              psel,
  output logic                              penable,
  output logic                              pwrite,
  output logic [msgbuf_pkg::ADDR_W-1:0]     paddr,
  output logic [msgbuf_pkg::DATA_W-1:0]     pwdata,
  output logic [msgbuf_pkg::USER_W-1:0]     pauser,
  input wire logic                          pready,
  input wire logic [msgbuf_pkg::DATA_W-1:0] prdata,
  input wire logic                          pslverr,
  // core firmware port
  output logic                              coreReq,
  output logic                              coreWrite,
  output logic [msgbuf_pkg::ADDR_W-1:0]     coreAddr,
  output logic [msgbuf_pkg::DATA_W-1:0]     coreWdata,
  input wire logic                          coreAck,
  input wire logic [msgbuf_pkg::DATA_W-1:0] coreRdata,
  input wire logic                          coreErr
);
  // idle at time zero
  initial begin
    {psel, penable, pwrite, coreReq, coreWrite} = 5'h00;
    {paddr, pwdata, pauser, coreAddr, coreWdata} = '0;
  end
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [USER_W-1:0] u, output logic [DATA_W-1:0] rd,
                     output logic err);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pauser  <= u;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    // no answer: stall here so the watchdog fails the run
    if (pready !== 1'b1) wait (1'b0);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a; // released lines do not keep the old value
    pwdata  <= ~d;
  endtask
  // core request held until acknowledged
  task automatic core(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] rd, output logic err);
    int n;
    @(posedge clk);
    coreReq   <= 1'b1;
    coreWrite <= w;
    coreAddr  <= a;
    coreWdata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (coreAck !== 1'b1 && n < 40);
    if (coreAck !== 1'b1) wait (1'b0);
    rd = coreRdata;
    err = coreErr;
    coreReq   <= 1'b0;
    coreWdata <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the message buffer block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import msgbuf_pkg::*;
  localparam logic [USER_W-1:0] UA = 8'h11;
  localparam logic [USER_W-1:0] UB = 8'h22;
  logic              clk, sysRst, bufEn, forceRel, resV, psel, penable, pwrite, pready, pslverr;
  logic              coreReq, coreWrite, coreAck, coreErr, coreIrq, socNotify, er;
  logic [ADDR_W-1:0] paddr, coreAddr;
  logic [USER_W-1:0] pauser, resU;
  logic [DATA_W-1:0] pwdata, prdata, coreWdata, coreRdata, rd;
  int                n_errors, checks_done, irq0;
  int                irqCnt = 0;
  msgbuf_partner p (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pauser(pauser), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .coreReq(coreReq), .coreWrite(coreWrite), .coreAddr(coreAddr), .coreWdata(coreWdata),
    .coreAck(coreAck), .coreRdata(coreRdata), .coreErr(coreErr));
  soc_core_mailbox_with_lock dut (.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pauser(pauser), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .coreReq(coreReq), .coreWrite(coreWrite),
    .coreAddr(coreAddr), .coreWdata(coreWdata), .coreAck(coreAck), .coreRdata(coreRdata),
    .coreErr(coreErr), .bufferEnable(bufEn), .lockForceRelease(forceRel),
    .lockReserveValid(resV), .lockReserveUser(resU), .coreIrq(coreIrq), .socNotify(socNotify));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // count interrupt pulses
  always @(posedge clk) if (coreIrq === 1'b1) irqCnt <= irqCnt + 1;
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task sr(input logic [ADDR_W-1:0] a, input logic [USER_W-1:0] u);
    p.apb(1'b0, a, 32'h0000_0000, u, rd, er);
  endtask
  task sw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [USER_W-1:0] u);
    p.apb(1'b1, a, d, u, rd, er);
  endtask
  task cr(input logic [ADDR_W-1:0] a);
    p.core(1'b0, a, 32'h0000_0000, rd, er);
  endtask
  task cw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    p.core(1'b1, a, d, rd, er);
  endtask
  task t_lock;
    sr(OFS_LOCK, UA);
    chk("lockA", rd, 32'h0000_0000);
    sr(OFS_LOCK, UB);
    chk("lockB", rd, 32'h0000_0001);
    cr(OFS_LOCK);
    chk("lockCore", rd, 32'h0000_0001);
    $display("t_lock done");
  endtask
  task t_send;
    sw(OFS_CMD, 32'h0000_00A5, UA);
    sw(OFS_DLEN, 32'h0000_0008, UA);
    sw(OFS_IN, 32'hCAFE_0001, UA);
    sw(OFS_IN, 32'hCAFE_0002, UA);
    sw(OFS_CMD, 32'h0000_005A, UB);
    sr(OFS_CMD, UB);
    chk("cmdOther", rd, 32'h0000_0000);
    sr(OFS_CMD, UA);
    chk("cmd", rd, 32'h0000_00A5);
    irq0 = irqCnt;
    sw(OFS_EXEC, 32'h0000_0001, UA);
    repeat (2) @(posedge clk);
    chk("irq", 32'(irqCnt - irq0), 32'h0000_0001);
    sr(OFS_STATUS, UA);
    chk("stBusy", rd, 32'(ST_BUSY));
    cr(OFS_CMD);
    chk("rxCmd", rd, 32'h0000_00A5);
    cr(OFS_DLEN);
    chk("rxLen", rd, 32'h0000_0008);
    cr(OFS_OUT);
    chk("rxW0", rd, 32'hCAFE_0001);
    cr(OFS_OUT);
    chk("rxW1", rd, 32'hCAFE_0002);
    cw(OFS_EXEC, 32'h0000_0000);
    sr(OFS_LOCK, UB);
    chk("relLock", rd, 32'h0000_0000);
    sw(OFS_EXEC, 32'h0000_0000, UB);
    $display("t_send done");
  endtask
  task t_core_send;
    cr(OFS_LOCK);
    chk("coreLock", rd, 32'h0000_0000);
    cw(OFS_CMD, 32'h0000_00C3);
    cw(OFS_DLEN, 32'h0000_0004);
    cw(OFS_IN, 32'h1234_5678);
    cw(OFS_EXEC, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("notify", {31'h0, socNotify}, 32'h0000_0001);
    sr(OFS_STATUS, UA);
    chk("stReady", rd, 32'(ST_DATA_READY));
    sr(OFS_CMD, UA);
    chk("socCmd", rd, 32'h0000_00C3);
    sr(OFS_OUT, UA);
    chk("socW0", rd, 32'h1234_5678);
    for (int c = 2; c < 4; c++) begin
      cw(OFS_STATUS, 32'(c));
      sr(OFS_STATUS, UA);
      chk("stCode", rd, 32'(c));
    end
    sw(OFS_EXEC, 32'h0000_0000, UA);
    repeat (2) @(posedge clk);
    chk("notifyClr", {31'h0, socNotify}, 32'h0000_0000);
    sr(OFS_LOCK, UA);
    chk("freeLock", rd, 32'h0000_0000);
    $display("t_core_send done");
  endtask
  task automatic t_perm;
    logic [ADDR_W-1:0] ro [4] = '{OFS_LOCK, OFS_OUT, OFS_STATUS, 8'h20};
    foreach (ro[i]) begin
      sw(ro[i], 32'h0000_0001, UA);
      chk("roErr", {31'h0, er}, 32'h0000_0001);
    end
    sr(OFS_IN, UA);
    chk("inRdErr", {31'h0, er}, 32'h0000_0001);
    sr(8'h40, UA);
    chk("unmapErr", {31'h0, er}, 32'h0000_0001);
    cr(OFS_IN);
    chk("coreInErr", {31'h0, er}, 32'h0000_0001);
    cw(8'h24, 32'h0000_BEEF);
    sr(8'h24, UA);
    chk("info", rd, 32'h0000_BEEF);
    sw(OFS_EXEC, 32'h0000_0000, UA);
    $display("t_perm done");
  endtask
  task t_guard;
    sr(OFS_LOCK, UB);
    sw(OFS_CMD, 32'h0000_0011, UB);
    @(posedge clk) bufEn <= 1'b0;
    sw(OFS_CMD, 32'h0000_0077, UB);
    sr(OFS_CMD, UB);
    chk("dropWr", rd, 32'h0000_0011);
    @(posedge clk) bufEn <= 1'b1;
    @(posedge clk) forceRel <= 1'b1;
    @(posedge clk) forceRel <= 1'b0;
    sr(OFS_LOCK, UA);
    chk("forced", rd, 32'h0000_0000);
    @(posedge clk) resV <= 1'b1;
    resU <= UB;
    sw(OFS_EXEC, 32'h0000_0000, UA);
    sr(OFS_LOCK, UA);
    chk("resA", rd, 32'h0000_0001);
    cr(OFS_LOCK);
    chk("resCore", rd, 32'h0000_0001);
    sr(OFS_LOCK, UB);
    chk("resB", rd, 32'h0000_0000);
    @(posedge clk) resV <= 1'b0;
    sw(OFS_EXEC, 32'h0000_0000, UB);
    $display("t_guard done");
  endtask
  task test_done;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("[ERR] watchdog exp done seen hang");
    test_done;
  end
  // main sequence
  initial begin
    {sysRst, bufEn, forceRel, resV, resU} = {4'hC, 8'h00};
    n_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    t_lock;
    t_send;
    t_core_send;
    t_perm;
    t_guard;
    test_done;
  end
endmodule
`default_nettype wire
